// ==== hw/sox_defines.svh ====
// Constants for the receive overhead extract ports
`ifndef SOX_DEFINES_SVH
`define SOX_DEFINES_SVH

// Master clock and port base rates in kHz
`define SOX_MASTER_KHZ 19440
`define SOX_TOH3_BASE_KHZ 6480
`define SOX_TOH1_BASE_KHZ 2160
`define SOX_POH_BASE_KHZ 648
`define SOX_SDCC_BASE_KHZ 216
`define SOX_LDCC_BASE_KHZ 2160
`define SOX_OW_BASE_KHZ 72

// Frame period in microseconds
`define SOX_FRAME_US 125

// Gapping: keep pulses out of a repeating period
`define SOX_TOH_PER 5
`define SOX_TOH_KEEP 4
`define SOX_POH_PER 9
`define SOX_POH_KEEP 8
`define SOX_SDCC_PER 9
`define SOX_SDCC_KEEP 8
`define SOX_LDCC_PER 15
`define SOX_LDCC_KEEP 4
`define SOX_OW_PER 9
`define SOX_OW_KEEP 8

// Bytes per frame per stream
`define SOX_TOH3_BYTES 81
`define SOX_TOH1_BYTES 27
`define SOX_POH_BYTES 9
`define SOX_SDCC_BYTES 3
`define SOX_LDCC_BYTES 9
`define SOX_OW_BYTES 1
`define SOX_OW_LANES 3

// Byte store layout: base index of each stream
`define SOX_TOH_BASE 0
`define SOX_POH_BASE 81
`define SOX_SDCC_BASE 90
`define SOX_LDCC_BASE 93
`define SOX_OW_BASE 102
`define SOX_STORE_BYTES 105

`endif

// ==== hw/sox_pkg.sv ====
// Types shared by the receive overhead extract block
package sox_pkg;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [7:0] data;
    } sox_oh_wr_s;

    typedef struct packed {
        logic ready;
        logic sts1;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
        logic [6:0] addr;
        logic [7:0] data;
    } sox_core_s;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic req_d;
        logic ack_tgl;
        logic mode_s1;
        logic mode_s2;
        logic frame_start;
        logic [11:0] frame_cnt;
        logic [104:0][7:0] store;
    } sox_link_s;

endpackage

// ==== hw/sox_rx_oh_extract.sv ====
// Receive overhead serial extract ports with core-side byte loading
// Functional notes
// [RULE1] Transport overhead bytes shift out serially, changing on the falling edge of its clock.
// [RULE2] In STS-3c mode the transport overhead clock is 6.48 MHz gapped to average 5.184 MHz.
// [RULE3] In STS-1 mode the transport overhead clock is 2.16 MHz gapped to average 1.728 MHz.
// [RULE4] The transport overhead clock changes only on falling edges of the master clock.
// [RULE5] Transport frame position is high exactly while bit 1 of the first A1 byte is out.
// [RULE6] Path overhead bytes shift out serially, changing on the falling edge of its clock.
// [RULE7] Path overhead clock is 648 kHz gapped to 576 kHz, moved on master falling edges.
// [RULE8] Path frame position is high while bit 1 of the J1 byte is on the path stream.
// [RULE9] Section DCC clock averages 192 kHz by removing pulses from a 216 kHz clock.
// [RULE10] Section DCC bytes D1 to D3 shift out, changing on falling section DCC clock edges.
// [RULE11] Line DCC clock averages 576 kHz by removing pulses from a 2.16 MHz clock.
// [RULE12] Line DCC bytes D4 to D12 shift out, changing on falling line DCC clock edges.
// [RULE13] Orderwire clock averages 64 kHz from a gapped 72 kHz clock for three lanes.
// [RULE14] E1, F1 and E2 go out on three lanes, each changing on falling orderwire clock edges.
// [RULE15] A one master cycle pulse marks the start of each byte on the orderwire lanes.
// [RULE16] Every serial byte goes out most significant bit first.
`timescale 1ns/10ps
`include "sox_defines.svh"

module sox_port #(
    parameter int LANES = 1,
    parameter int BYTES = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic frame_start,
    input wire logic [8:0] div,
    input wire logic [3:0] per,
    input wire logic [3:0] keep,
    input wire logic [9:0] nbits,
    input wire logic [LANES*BYTES*8-1:0] bits,
    output logic port_clk,
    output logic [LANES-1:0] data,
    output logic frame_pos,
    output logic byte_pulse
);
    import sox_pkg::*;

    localparam int W = LANES * BYTES * 8;

    typedef struct packed {
        logic [8:0] cnt;
        logic [3:0] phase;
        logic [9:0] bidx;
        logic clk;
        logic fp;
        logic bpulse;
        logic [LANES-1:0] data;
    } sox_port_s;

    sox_port_s s;
    sox_port_s next_s;

    // Msb of each byte first
    function automatic logic [LANES-1:0] sox_pick(
        input logic [W-1:0] v,
        input logic [9:0] idx
    );
        logic [LANES-1:0] r;
        int pos;
        r = '0;
        for (int l = 0; l < LANES; l++)
        begin
            pos = l * BYTES * 8 + int'(idx[9:3]) * 8 + 7 - int'(idx[2:0]);
            // Past its last byte a lane goes quiet rather than show its neighbour
            if ((int'(idx[9:3]) < BYTES) && (pos < W))
            begin
                r[l] = v[pos];
            end
        end
        return r;
    endfunction

    always_comb
    begin
        next_s = s;
        if (rst)
        begin
            next_s = '0;
            // Spent bit index keeps the port silent until the first frame start
            next_s.bidx = 10'h3ff;
        end
        else if (frame_start)
        begin
            // Park one step before the first pulse so data leads the rising edge
            next_s.cnt = div - 9'h001;
            next_s.phase = per - 4'h1;
            next_s.bidx = '0;
            next_s.clk = 1'b0;
            next_s.fp = 1'b1; // [RULE5] [RULE8]
            next_s.bpulse = 1'b1; // [RULE15]
            next_s.data = sox_pick(bits, 10'h000); // [RULE16]
        end
        else
        begin
            next_s.bpulse = 1'b0;
            if (s.cnt == div - 9'h001)
            begin
                next_s.cnt = '0;
                next_s.phase = (s.phase == per - 4'h1) ? 4'h0 : s.phase + 4'h1;
                // Gapped pulses stay low; exhausted streams stop until the next frame
                if ((next_s.phase < keep) && (s.bidx < nbits)) // [RULE9] [RULE11] [RULE13]
                begin
                    next_s.clk = 1'b1; // [RULE2] [RULE3] [RULE7]
                end
            end
            else
            begin
                next_s.cnt = s.cnt + 9'h001;
                if ((next_s.cnt == {1'b0, div[8:1]}) && s.clk)
                begin
                    // Falling port clock edge moves data to the next bit
                    next_s.clk = 1'b0; // [RULE4]
                    next_s.bidx = s.bidx + 10'h001;
                    next_s.data = sox_pick(bits, next_s.bidx); // [RULE1] [RULE6] [RULE10] [RULE12] [RULE14]
                    next_s.fp = 1'b0; // [RULE5] [RULE8]
                    next_s.bpulse = (next_s.bidx[2:0] == 3'h0) && (next_s.bidx < nbits); // [RULE15]
                end
            end
        end
    end

    // Master falling edge clocks all link-side state
    always_ff @(negedge mclk)
    begin
        s <= next_s; // [RULE4] [RULE7]
    end

    assign port_clk = s.clk;
    assign data = s.data;
    assign frame_pos = s.fp;
    assign byte_pulse = s.bpulse;
endmodule

module sox_rx_oh_extract #(
    parameter int MASTER_KHZ = `SOX_MASTER_KHZ
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire sox_pkg::sox_oh_wr_s oh_wr,
    input wire logic sts1_mode,
    output logic wr_ready,
    input wire logic rx_oh_master_clk,
    output logic rx_transport_oh_data,
    output logic rx_transport_oh_clk,
    output logic rx_transport_oh_frame_pos,
    output logic rx_path_oh_data,
    output logic rx_path_oh_clk,
    output logic rx_path_oh_frame_pos,
    output logic rx_section_dcc_clk,
    output logic rx_section_dcc_data,
    output logic rx_line_dcc_clk,
    output logic rx_line_dcc_data,
    output logic rx_orderwire_clk,
    output logic rx_section_orderwire,
    output logic rx_section_user_chan,
    output logic rx_line_orderwire,
    output logic rx_orderwire_byte_pulse
);
    import sox_pkg::*;

    localparam int FRAME_CYC = MASTER_KHZ * `SOX_FRAME_US / 1000;
    localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYC - 1);
    localparam logic [8:0] DIV_TOH3 = 9'(MASTER_KHZ / `SOX_TOH3_BASE_KHZ);
    localparam logic [8:0] DIV_TOH1 = 9'(MASTER_KHZ / `SOX_TOH1_BASE_KHZ);
    localparam logic [8:0] DIV_POH = 9'(MASTER_KHZ / `SOX_POH_BASE_KHZ);
    localparam logic [8:0] DIV_SDCC = 9'(MASTER_KHZ / `SOX_SDCC_BASE_KHZ);
    localparam logic [8:0] DIV_LDCC = 9'(MASTER_KHZ / `SOX_LDCC_BASE_KHZ);
    localparam logic [8:0] DIV_OW = 9'(MASTER_KHZ / `SOX_OW_BASE_KHZ);
    localparam logic [9:0] BITS_TOH3 = 10'(`SOX_TOH3_BYTES * 8);
    localparam logic [9:0] BITS_TOH1 = 10'(`SOX_TOH1_BYTES * 8);

    sox_core_s c;
    sox_core_s next_c;
    sox_link_s l;
    sox_link_s next_l;
    logic link_rst;
    logic [2:0] ow_data;
    logic ow_fp;

    // Core side: one byte in flight; the link echoes the toggle when stored
    always_comb
    begin
        next_c = c;
        next_c.ack_s1 = l.ack_tgl;
        next_c.ack_s2 = c.ack_s1;
        next_c.sts1 = sts1_mode;
        if (oh_wr.valid && c.ready)
        begin
            next_c.addr = oh_wr.addr;
            next_c.data = oh_wr.data;
            next_c.req_tgl = ~c.req_tgl;
        end
        next_c.ready = (next_c.req_tgl == next_c.ack_s2);
        if (sys_rst)
        begin
            next_c = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        c <= next_c;
    end

    assign wr_ready = c.ready;
    assign link_rst = l.rst_s2;

    // Link side: addr and data are stable while the request toggle differs
    always_comb
    begin
        next_l = l;
        next_l.rst_s1 = sys_rst;
        next_l.rst_s2 = l.rst_s1;
        next_l.req_s1 = c.req_tgl;
        next_l.req_s2 = l.req_s1;
        next_l.mode_s1 = c.sts1;
        next_l.mode_s2 = l.mode_s1;
        next_l.req_d = l.req_s2;
        if (l.req_s2 != l.req_d)
        begin
            // Out of range addresses are acknowledged and dropped
            if (c.addr < 7'(`SOX_STORE_BYTES))
            begin
                next_l.store[c.addr] = c.data;
            end
            next_l.ack_tgl = l.req_s2;
        end
        next_l.frame_start = (l.frame_cnt == FRAME_LAST);
        next_l.frame_cnt = next_l.frame_start ? 12'h000 : l.frame_cnt + 12'h001;
        if (l.rst_s2)
        begin
            next_l.req_d = 1'b0;
            next_l.ack_tgl = 1'b0;
            next_l.frame_start = 1'b0;
            next_l.frame_cnt = '0;
            next_l.store = '0;
        end
    end

    // Store is read live, so a rewrite mid-frame may show on the stream
    always_ff @(negedge rx_oh_master_clk)
    begin
        l <= next_l;
    end

    sox_port #(
        .LANES(1),
        .BYTES(`SOX_TOH3_BYTES)
    ) u_toh (
        .mclk(rx_oh_master_clk),
        .rst(link_rst),
        .frame_start(l.frame_start),
        .div(l.mode_s2 ? DIV_TOH1 : DIV_TOH3), // [RULE2] [RULE3]
        .per(4'(`SOX_TOH_PER)),
        .keep(4'(`SOX_TOH_KEEP)),
        .nbits(l.mode_s2 ? BITS_TOH1 : BITS_TOH3),
        .bits(l.store[`SOX_TOH_BASE +: `SOX_TOH3_BYTES]), // [RULE1]
        .port_clk(rx_transport_oh_clk),
        .data(rx_transport_oh_data),
        .frame_pos(rx_transport_oh_frame_pos),
        .byte_pulse()
    );

    sox_port #(
        .LANES(1),
        .BYTES(`SOX_POH_BYTES)
    ) u_poh (
        .mclk(rx_oh_master_clk),
        .rst(link_rst),
        .frame_start(l.frame_start),
        .div(DIV_POH), // [RULE7]
        .per(4'(`SOX_POH_PER)),
        .keep(4'(`SOX_POH_KEEP)),
        .nbits(10'(`SOX_POH_BYTES * 8)),
        .bits(l.store[`SOX_POH_BASE +: `SOX_POH_BYTES]), // [RULE6]
        .port_clk(rx_path_oh_clk),
        .data(rx_path_oh_data),
        .frame_pos(rx_path_oh_frame_pos),
        .byte_pulse()
    );

    sox_port #(
        .LANES(1),
        .BYTES(`SOX_SDCC_BYTES)
    ) u_sdcc (
        .mclk(rx_oh_master_clk),
        .rst(link_rst),
        .frame_start(l.frame_start),
        .div(DIV_SDCC), // [RULE9]
        .per(4'(`SOX_SDCC_PER)),
        .keep(4'(`SOX_SDCC_KEEP)),
        .nbits(10'(`SOX_SDCC_BYTES * 8)),
        .bits(l.store[`SOX_SDCC_BASE +: `SOX_SDCC_BYTES]), // [RULE10]
        .port_clk(rx_section_dcc_clk),
        .data(rx_section_dcc_data),
        .frame_pos(),
        .byte_pulse()
    );

    sox_port #(
        .LANES(1),
        .BYTES(`SOX_LDCC_BYTES)
    ) u_ldcc (
        .mclk(rx_oh_master_clk),
        .rst(link_rst),
        .frame_start(l.frame_start),
        .div(DIV_LDCC), // [RULE11]
        .per(4'(`SOX_LDCC_PER)),
        .keep(4'(`SOX_LDCC_KEEP)),
        .nbits(10'(`SOX_LDCC_BYTES * 8)),
        .bits(l.store[`SOX_LDCC_BASE +: `SOX_LDCC_BYTES]), // [RULE12]
        .port_clk(rx_line_dcc_clk),
        .data(rx_line_dcc_data),
        .frame_pos(),
        .byte_pulse()
    );

    // Lane 0 E1, lane 1 F1, lane 2 E2
    sox_port #(
        .LANES(`SOX_OW_LANES),
        .BYTES(`SOX_OW_BYTES)
    ) u_ow (
        .mclk(rx_oh_master_clk),
        .rst(link_rst),
        .frame_start(l.frame_start),
        .div(DIV_OW), // [RULE13]
        .per(4'(`SOX_OW_PER)),
        .keep(4'(`SOX_OW_KEEP)),
        .nbits(10'(`SOX_OW_BYTES * 8)),
        .bits(l.store[`SOX_OW_BASE +: `SOX_OW_LANES]), // [RULE14]
        .port_clk(rx_orderwire_clk),
        .data(ow_data),
        .frame_pos(ow_fp),
        .byte_pulse(rx_orderwire_byte_pulse) // [RULE15]
    );

    assign rx_section_orderwire = ow_data[0];
    assign rx_section_user_chan = ow_data[1];
    assign rx_line_orderwire = ow_data[2];
endmodule

// ==== test/sox_oh_sink.sv ====
// Far-side serial overhead receiver, one per stream
`timescale 1ns/10ps
module sox_oh_sink (
    input wire logic port_clk,
    input wire logic data,
    input wire logic mark
);
    logic [7:0] bytes [0:80];
    logic [7:0] shift = '0;
    int idx = 0;
    // Data only settles between falls, so take it at the rise
    always @(posedge port_clk)
    begin
        idx = (mark === 1'b1) ? 0 : idx + 1;
        shift = {shift[6:0], data};
        if (idx % 8 == 7 && idx < 648)
        begin
            bytes[idx / 8] = shift;
        end
    end
endmodule

// ==== test/sox_rx_oh_extract_monitor.sv ====
// Concurrent checks on the serial overhead extract ports
`timescale 1ns/10ps
module sox_rx_oh_extract_monitor (
    input wire logic sys_rst,
    input wire logic rx_oh_master_clk,
    input wire logic rx_transport_oh_data,
    input wire logic rx_transport_oh_clk,
    input wire logic rx_transport_oh_frame_pos,
    input wire logic rx_path_oh_data,
    input wire logic rx_path_oh_clk,
    input wire logic rx_path_oh_frame_pos,
    input wire logic rx_section_dcc_clk,
    input wire logic rx_section_dcc_data,
    input wire logic rx_line_dcc_clk,
    input wire logic rx_line_dcc_data,
    input wire logic rx_orderwire_clk,
    input wire logic rx_section_orderwire,
    input wire logic rx_section_user_chan,
    input wire logic rx_line_orderwire,
    input wire logic rx_orderwire_byte_pulse
);
    import sox_pkg::*;
    logic toh_q;
    logic poh_q;
    default clocking cb @(negedge rx_oh_master_clk);
    endclocking
    default disable iff (sys_rst);
    // Taken at rises, compared at falls: any move between them is a glitch
    always_ff @(posedge rx_oh_master_clk)
    begin
        toh_q <= rx_transport_oh_clk;
        poh_q <= rx_path_oh_clk;
    end
    property p_toh_edge;
        @(negedge rx_oh_master_clk) disable iff (sys_rst) rx_transport_oh_clk == toh_q;
    endproperty
    a_toh_edge: assert property (p_toh_edge) else $error("transport clock off edge");
    property p_poh_edge;
        @(negedge rx_oh_master_clk) disable iff (sys_rst) rx_path_oh_clk == poh_q;
    endproperty
    a_poh_edge: assert property (p_poh_edge) else $error("path clock off edge");
    property p_toh_data;
        $changed(rx_transport_oh_data) |->
            $fell(rx_transport_oh_clk) || $rose(rx_transport_oh_frame_pos);
    endproperty
    a_toh_data: assert property (p_toh_data) else $error("transport data moved");
    property p_toh_fp_on;
        $rose(rx_transport_oh_frame_pos) |-> !rx_transport_oh_clk ##1 $rose(rx_transport_oh_clk);
    endproperty
    a_toh_fp_on: assert property (p_toh_fp_on) else $error("transport marker start");
    property p_toh_fp_off;
        $fell(rx_transport_oh_frame_pos) |-> $fell(rx_transport_oh_clk);
    endproperty
    a_toh_fp_off: assert property (p_toh_fp_off) else $error("transport marker end");
    property p_poh_data;
        $changed(rx_path_oh_data) |-> $fell(rx_path_oh_clk) || $rose(rx_path_oh_frame_pos);
    endproperty
    a_poh_data: assert property (p_poh_data) else $error("path data moved");
    property p_poh_fp;
        $rose(rx_path_oh_frame_pos) |-> !rx_path_oh_clk ##1 $rose(rx_path_oh_clk)
            ##15 $fell(rx_path_oh_clk) && !rx_path_oh_frame_pos;
    endproperty
    a_poh_fp: assert property (p_poh_fp) else $error("path marker timing");
    property p_sdcc_data;
        $changed(rx_section_dcc_data) |->
            $fell(rx_section_dcc_clk) || $rose(rx_transport_oh_frame_pos);
    endproperty
    a_sdcc_data: assert property (p_sdcc_data) else $error("section dcc moved");
    property p_ldcc_data;
        $changed(rx_line_dcc_data) |-> $fell(rx_line_dcc_clk) || $rose(rx_transport_oh_frame_pos);
    endproperty
    a_ldcc_data: assert property (p_ldcc_data) else $error("line dcc moved");
    property p_ldcc_hi;
        $rose(rx_line_dcc_clk) |=> rx_line_dcc_clk[*3] ##1 $fell(rx_line_dcc_clk);
    endproperty
    a_ldcc_hi: assert property (p_ldcc_hi) else $error("line dcc pulse width");
    property p_ow_data;
        $changed({rx_section_orderwire, rx_section_user_chan, rx_line_orderwire}) |->
            $fell(rx_orderwire_clk) || $rose(rx_orderwire_byte_pulse);
    endproperty
    a_ow_data: assert property (p_ow_data) else $error("orderwire lane moved");
    property p_ow_pulse;
        rx_orderwire_byte_pulse |-> $rose(rx_transport_oh_frame_pos) ##1 !rx_orderwire_byte_pulse;
    endproperty
    a_ow_pulse: assert property (p_ow_pulse) else $error("byte pulse shape");
endmodule

bind sox_rx_oh_extract sox_rx_oh_extract_monitor sox_rx_oh_extract_monitor_i (
    .sys_rst, .rx_oh_master_clk, .rx_transport_oh_data, .rx_transport_oh_clk,
    .rx_transport_oh_frame_pos, .rx_path_oh_data, .rx_path_oh_clk, .rx_path_oh_frame_pos,
    .rx_section_dcc_clk, .rx_section_dcc_data, .rx_line_dcc_clk, .rx_line_dcc_data,
    .rx_orderwire_clk, .rx_section_orderwire, .rx_section_user_chan, .rx_line_orderwire,
    .rx_orderwire_byte_pulse
);

// ==== test/tb_sox_rx_oh_extract.sv ====
// Self-checking bench for the receive overhead extract ports
`timescale 1ns/10ps
module tb_sox_rx_oh_extract;
    import sox_pkg::*;
    typedef struct {int addr; logic [7:0] val; int lane; int pos;} sox_row_s;
    logic ref_clk = 1'b0;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic sts1_mode = 1'b0;
    sox_oh_wr_s oh_wr = '0;
    logic wr_ready, toh_d, toh_c, toh_fp, poh_d, poh_c, poh_fp, sd_c, sd_d, ld_c, ld_d;
    logic ow_c, e1, f1, e2, ow_bp;
    logic [4:0] pc;
    logic [4:0] pc_q = '0;
    logic fp_q = 1'b0;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    sox_row_s rows [11];
    int rises [5] = '{default: 0};
    int gap [5] = '{default: 0};
    int mingap [5] = '{default: 99999};
    int last_rises [5] = '{default: 0};
    int last_gap [5] = '{default: 0};
    int avg_khz [5] = '{5184, 576, 192, 576, 64};
    int base_khz [5] = '{6480, 648, 216, 2160, 72};

    sox_rx_oh_extract sox_rx_oh_extract_i (
        .ref_clk, .sys_rst, .oh_wr, .sts1_mode, .wr_ready, .rx_oh_master_clk(mclk),
        .rx_transport_oh_data(toh_d), .rx_transport_oh_clk(toh_c),
        .rx_transport_oh_frame_pos(toh_fp), .rx_path_oh_data(poh_d), .rx_path_oh_clk(poh_c),
        .rx_path_oh_frame_pos(poh_fp), .rx_section_dcc_clk(sd_c), .rx_section_dcc_data(sd_d),
        .rx_line_dcc_clk(ld_c), .rx_line_dcc_data(ld_d), .rx_orderwire_clk(ow_c),
        .rx_section_orderwire(e1), .rx_section_user_chan(f1), .rx_line_orderwire(e2),
        .rx_orderwire_byte_pulse(ow_bp)
    );
    sox_oh_sink sink_toh (.port_clk(toh_c), .data(toh_d), .mark(toh_fp));
    sox_oh_sink sink_poh (.port_clk(poh_c), .data(poh_d), .mark(poh_fp));
    sox_oh_sink sink_sd (.port_clk(sd_c), .data(sd_d), .mark(toh_fp));
    sox_oh_sink sink_ld (.port_clk(ld_c), .data(ld_d), .mark(toh_fp));
    sox_oh_sink sink_e1 (.port_clk(ow_c), .data(e1), .mark(toh_fp));
    sox_oh_sink sink_f1 (.port_clk(ow_c), .data(f1), .mark(toh_fp));
    sox_oh_sink sink_e2 (.port_clk(ow_c), .data(e2), .mark(toh_fp));

    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Odd start offset keeps the two clocks out of phase
    initial
    begin
        #7;
        forever #40 mclk = ~mclk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            fails++;
            $display("[FAIL] %0t run too long", $time);
            summarize();
        end
    end
    // Pulse count and closest rise spacing per frame, in master cycles
    assign pc = {ow_c, ld_c, sd_c, poh_c, toh_c};
    always @(posedge mclk)
    begin
        for (int i = 0; i < 5; i++)
        begin
            gap[i]++;
            if (pc[i] === 1'b1 && pc_q[i] !== 1'b1)
            begin
                rises[i]++;
                mingap[i] = (gap[i] < mingap[i]) ? gap[i] : mingap[i];
                gap[i] = 0;
            end
        end
        if (toh_fp === 1'b1 && fp_q !== 1'b1)
        begin
            last_rises = rises;
            last_gap = mingap;
            rises = '{default: 0};
            mingap = '{default: 99999};
        end
        pc_q = pc;
        fp_q = toh_fp;
    end

    task chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Request held until ready is seen high at a rising edge
    task wr(input int a, input logic [7:0] v);
        int n;
        n = 0;
        @(negedge ref_clk);
        oh_wr.valid = 1'b1;
        oh_wr.addr = 7'(a);
        oh_wr.data = v;
        do @(posedge ref_clk); while (wr_ready !== 1'b1 && ++n < 50);
        @(negedge ref_clk);
        oh_wr.valid = 1'b0;
        chk(n < 50, "write not taken");
    endtask
    task frames(input int n);
        repeat (n) @(posedge toh_fp);
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [7:0] got(input int l, input int p);
        case (l)
            0: return sink_toh.bytes[p];
            1: return sink_poh.bytes[p];
            2: return sink_sd.bytes[p];
            3: return sink_ld.bytes[p];
            4: return sink_e1.bytes[p];
            5: return sink_f1.bytes[p];
            default: return sink_e2.bytes[p];
        endcase
    endfunction
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        rows = '{'{0, 8'h96, 0, 0}, '{80, 8'h3c, 0, 80}, '{81, 8'he1, 1, 0}, '{89, 8'h5a, 1, 8},
            '{90, 8'h81, 2, 0}, '{92, 8'h7e, 2, 2}, '{93, 8'hc3, 3, 0}, '{101, 8'h18, 3, 8},
            '{102, 8'ha5, 4, 0}, '{103, 8'h69, 5, 0}, '{104, 8'hf0, 6, 0}};
        repeat (5) @(negedge mclk);
        chk(wr_ready === 1'b0, "ready during reset");
        chk({toh_c, poh_c, sd_c, ld_c, ow_c, toh_d, toh_fp, ow_bp} === 8'h00, "reset outputs");
        @(negedge ref_clk);
        sys_rst = 1'b0;
        @(posedge ref_clk);
        #1;
        chk(wr_ready === 1'b1, "ready after reset");
        $display("test reset done");
        foreach (rows[i]) wr(rows[i].addr, rows[i].val);
        // Unmapped place must be acked and leave every stream alone
        wr(120, 8'hff);
        frames(2);
        foreach (rows[i])
        begin
            chk(got(rows[i].lane, rows[i].pos) === rows[i].val, "serial byte");
        end
        for (int i = 0; i < 5; i++)
        begin
            chk(last_rises[i] == avg_khz[i] * 125 / 1000, "pulses per frame");
            chk(last_gap[i] == `SOX_MASTER_KHZ / base_khz[i], "base period");
        end
        $display("test streams done");
        @(negedge ref_clk);
        sts1_mode = 1'b1;
        frames(3);
        chk(last_rises[0] == 1728 * 125 / 1000, "sts1 pulses");
        chk(last_gap[0] == `SOX_MASTER_KHZ / 2160, "sts1 base period");
        chk(got(0, 0) === rows[0].val, "sts1 first byte");
        $display("test sts1 done");
        summarize();
    end
endmodule
